/* File: hdl/sadc_pkg.sv */
package sadc_pkg;
    // core clock and internal conversion oscillator
    localparam int CORE_CLK_HZ = 50_000_000;
    localparam int INT_OSC_HZ = 1_000_000;
    localparam int OSC_HALF_CYC = CORE_CLK_HZ / (2 * INT_OSC_HZ);
    // highest conversion rate, 11.1 kHz; least spacing rounds up
    localparam int CONV_RATE_HZ = 11_100;
    localparam int CONV_MIN_CYC =
        (CORE_CLK_HZ + CONV_RATE_HZ - 1) / CONV_RATE_HZ;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DAC_RESET = 8'h00;
    localparam logic [7:0] ADC_RESET = 8'h80;
    // converter_control field layout
    localparam int CTRL_OUT_EN_BIT = 6;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_AUTOINC_BIT = 2;
    localparam int CTRL_CHAN_LSB = 0;
    // input configurations held in the mode field
    localparam logic [1:0] MODE_FOUR_SINGLE = 2'h0;
    localparam logic [1:0] MODE_THREE_DIFF = 2'h1;
    localparam logic [1:0] MODE_MIXED = 2'h2;
    localparam logic [1:0] MODE_TWO_DIFF = 2'h3;
    // offset binary to two's complement
    localparam logic [7:0] DIFF_FLIP = 8'h80;
    localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;
    localparam int DATA_BITS = 8;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_TX_FALL = 4'h7;
    localparam int RESULT_FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADDR = 3'b001,
        BUS_ADDR_ACK = 3'b010,
        BUS_WR_BYTE = 3'b011,
        BUS_WR_ACK = 3'b100,
        BUS_RD_BYTE = 3'b101,
        BUS_RD_ACK = 3'b110
    } sadc_bus_state_t;
endpackage

/* File: hdl/sadc_fifo.sv */
`timescale 1ns/10ps
module sadc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } sadc_fifo_state_t;

    sadc_fifo_state_t fifo_reg;
    sadc_fifo_state_t fifo_next;
    logic full;
    logic empty;

    // extra pointer bit tells full from empty
    assign empty = fifo_reg.wr_ptr == fifo_reg.rd_ptr;
    assign full = (fifo_reg.wr_ptr[AW] != fifo_reg.rd_ptr[AW])
        && (fifo_reg.wr_ptr[AW-1:0] == fifo_reg.rd_ptr[AW-1:0]);
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = fifo_reg.mem[fifo_reg.rd_ptr[AW-1:0]];

    always_comb
    begin
        fifo_next = fifo_reg;
        if (in_valid_i && !full)
        begin
            fifo_next.mem[fifo_reg.wr_ptr[AW-1:0]] = in_data_i;
            fifo_next.wr_ptr = fifo_reg.wr_ptr + 1'b1;
        end
        if (out_ready_i && !empty)
        begin
            fifo_next.rd_ptr = fifo_reg.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            fifo_reg <= '0;
        end
        else
        begin
            fifo_reg <= fifo_next;
        end
    end
endmodule

/* File: hdl/sadc_sar.sv */
`timescale 1ns/10ps
module sadc_sar (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic tick_i,
    input wire logic comparator_i,
    output logic busy_o,
    output logic [7:0] trial_o,
    output logic res_valid_o,
    input wire logic res_ready_i,
    output logic [7:0] res_o
);
    typedef struct packed {
        logic run;
        logic done;
        logic [7:0] trial;
        logic [7:0] probe;
    } sadc_sar_state_t;

    sadc_sar_state_t sar_reg;
    sadc_sar_state_t sar_next;

    // busy until the result has left, so the ladder stays borrowed
    assign busy_o = sar_reg.run | sar_reg.done;
    assign trial_o = sar_reg.trial;
    assign res_valid_o = sar_reg.done;
    assign res_o = sar_reg.trial;

    always_comb
    begin
        sar_next = sar_reg;
        if (start_i && !busy_o)
        begin
            sar_next.run = 1'b1;
            sar_next.trial = sadc_pkg::SAR_FIRST_TRIAL;
            sar_next.probe = sadc_pkg::SAR_FIRST_TRIAL;
        end
        else if (sar_reg.run && tick_i)
        begin
            // comparator high: input above trial, keep the bit
            if (!comparator_i)
            begin
                sar_next.trial = sar_reg.trial & ~sar_reg.probe;
            end
            sar_next.probe = sar_reg.probe >> 1;
            sar_next.trial = sar_next.trial | (sar_reg.probe >> 1);
            if (sar_reg.probe[0])
            begin
                sar_next.run = 1'b0;
                sar_next.done = 1'b1;
            end
        end
        else if (sar_reg.done && res_ready_i)
        begin
            sar_next.done = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            sar_reg <= '0;
        end
        else
        begin
            sar_reg <= sar_next;
        end
    end
endmodule

/* File: hdl/sadc_core.sv */
`timescale 1ns/10ps
module sadc_core #(
    parameter int CONV_MIN_CYC = sadc_pkg::CONV_MIN_CYC,
    // fixed address part; arbitrary neutral value
    parameter logic [3:0] ADDR_FIXED = 4'h5
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic address_select_bit_zero_i,
    input wire logic address_select_bit_one_i,
    input wire logic address_select_bit_two_i,
    input wire logic external_clock_select_i,
    input wire logic oscillator_pin_i,
    output logic oscillator_pin_o,
    output logic oscillator_pin_oe_o,
    output logic osc_enable_o,
    input wire logic comparator_i,
    output logic [7:0] dac_code_o,
    output logic out_enable_o,
    output logic track_hold_o,
    output logic [1:0] input_mode_o,
    output logic [1:0] input_channel_o
);
    typedef struct packed {
        logic [1:0] scl_sync;
        logic [1:0] sda_sync;
        logic [1:0] osc_sync;
        logic [1:0] ext_sync;
        logic scl_prev;
        logic sda_prev;
        logic osc_prev;
        sadc_pkg::sadc_bus_state_t bus;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] tx;
        logic rw;
        logic ctrl_seen;
        logic acked;
        logic drive;
        logic [7:0] ctrl;
        logic [7:0] dac;
        logic [7:0] adc;
        logic conv_pend;
        logic conv_diff;
        logic [15:0] gap_cnt;
        logic [7:0] osc_div;
        logic osc_level;
    } sadc_core_state_t;

    sadc_core_state_t core_reg;
    sadc_core_state_t core_next;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic osc_tick;
    logic osc_en;
    logic sar_start;
    logic sar_busy;
    logic [7:0] sar_trial;
    logic sar_valid;
    logic sar_ready;
    logic [7:0] sar_res;
    logic fifo_valid;
    logic fifo_pop;
    logic [7:0] fifo_data;
    logic [7:0] fifo_in;
    logic [1:0] mode;
    logic [1:0] chan_eff;
    logic tx_load;

    // highest channel that the input configuration offers
    function automatic logic [1:0] max_chan(input logic [1:0] m);
        logic [1:0] r;
        r = 2'h2;
        if (m == sadc_pkg::MODE_FOUR_SINGLE)
        begin
            r = 2'h3;
        end
        else if (m == sadc_pkg::MODE_TWO_DIFF)
        begin
            r = 2'h1;
        end
        return r;
    endfunction

    function automatic logic is_diff(input logic [1:0] m,
                                     input logic [1:0] c);
        return (m == sadc_pkg::MODE_THREE_DIFF)
            || (m == sadc_pkg::MODE_TWO_DIFF)
            || ((m == sadc_pkg::MODE_MIXED) && (c == 2'h2));
    endfunction

    assign mode = core_reg.ctrl[sadc_pkg::CTRL_MODE_LSB +: 2];
    assign chan_eff =
        (core_reg.ctrl[sadc_pkg::CTRL_CHAN_LSB +: 2] > max_chan(mode))
        ? max_chan(mode) : core_reg.ctrl[sadc_pkg::CTRL_CHAN_LSB +: 2];

    assign scl_rise = core_reg.scl_sync[1] & ~core_reg.scl_prev;
    assign scl_fall = ~core_reg.scl_sync[1] & core_reg.scl_prev;
    assign start_cond = core_reg.scl_sync[1] & core_reg.scl_prev
        & ~core_reg.sda_sync[1] & core_reg.sda_prev;
    assign stop_cond = core_reg.scl_sync[1] & core_reg.scl_prev
        & core_reg.sda_sync[1] & ~core_reg.sda_prev;

    // internal divider or external pin edges
    assign osc_tick = core_reg.ext_sync[1]
        ? (core_reg.osc_sync[1] & ~core_reg.osc_prev)
        : (osc_en && core_reg.osc_div == 8'h00 && !core_reg.osc_level);
    // oscillator sleeps unless output or converter needs it
    assign osc_en = core_reg.ctrl[sadc_pkg::CTRL_OUT_EN_BIT]
        | core_reg.conv_pend | sar_busy;

    assign sar_start = core_reg.conv_pend && !sar_busy
        && core_reg.gap_cnt == 16'h0000;
    assign fifo_in = core_reg.conv_diff
        ? (sar_res ^ sadc_pkg::DIFF_FLIP) : sar_res;

    // byte load at the trailing edge of an acked ninth clock
    assign tx_load = scl_fall && !start_cond && !stop_cond
        && ((core_reg.bus == sadc_pkg::BUS_ADDR_ACK && core_reg.rw)
        || (core_reg.bus == sadc_pkg::BUS_RD_ACK && core_reg.acked));
    assign fifo_pop = tx_load & fifo_valid;

    assign sda_o = 1'b0;
    assign sda_oe_o = ~core_reg.drive;
    assign oscillator_pin_o = core_reg.osc_level;
    assign oscillator_pin_oe_o = core_reg.ext_sync[1];
    assign osc_enable_o = osc_en;
    assign track_hold_o = sar_busy;
    assign dac_code_o = sar_busy ? sar_trial : core_reg.dac;
    assign out_enable_o = core_reg.ctrl[sadc_pkg::CTRL_OUT_EN_BIT];
    assign input_mode_o = mode;
    assign input_channel_o = chan_eff;

    sadc_sar u_sar (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .start_i(sar_start),
        .tick_i(osc_tick),
        .comparator_i(comparator_i),
        .busy_o(sar_busy),
        .trial_o(sar_trial),
        .res_valid_o(sar_valid),
        .res_ready_i(sar_ready),
        .res_o(sar_res)
    );

    // results queue; a full queue stalls the converter
    sadc_fifo #(
        .WIDTH(sadc_pkg::DATA_BITS),
        .DEPTH(sadc_pkg::RESULT_FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_valid_i(sar_valid),
        .in_ready_o(sar_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    always_comb
    begin
        core_next = core_reg;
        // two-stage sync, 50 MHz far above bit rate
        core_next.scl_sync = {core_reg.scl_sync[0], scl_i};
        core_next.sda_sync = {core_reg.sda_sync[0], sda_i};
        core_next.osc_sync = {core_reg.osc_sync[0], oscillator_pin_i};
        core_next.ext_sync = {core_reg.ext_sync[0],
                              external_clock_select_i};
        core_next.scl_prev = core_reg.scl_sync[1];
        core_next.sda_prev = core_reg.sda_sync[1];
        core_next.osc_prev = core_reg.osc_sync[1];

        if (!osc_en || core_reg.ext_sync[1])
        begin
            core_next.osc_div = 8'h00;
            core_next.osc_level = 1'b0;
        end
        else if (core_reg.osc_div ==
                 8'(sadc_pkg::OSC_HALF_CYC - 1))
        begin
            core_next.osc_div = 8'h00;
            core_next.osc_level = ~core_reg.osc_level;
        end
        else
        begin
            core_next.osc_div = core_reg.osc_div + 8'h01;
        end

        if (core_reg.gap_cnt != 16'h0000)
        begin
            core_next.gap_cnt = core_reg.gap_cnt - 16'h0001;
        end
        if (sar_start)
        begin
            core_next.conv_pend = 1'b0;
            core_next.conv_diff = is_diff(mode, chan_eff);
            core_next.gap_cnt = 16'(CONV_MIN_CYC - 1);
        end
        // advance channel once the result is taken
        if (sar_valid && sar_ready
            && core_reg.ctrl[sadc_pkg::CTRL_AUTOINC_BIT])
        begin
            core_next.ctrl[sadc_pkg::CTRL_CHAN_LSB +: 2] =
                (chan_eff == max_chan(mode)) ? 2'h0 : chan_eff + 2'h1;
        end

        if (tx_load)
        begin
            // queued result becomes the data register
            core_next.adc = fifo_valid ? fifo_data : core_reg.adc;
            core_next.tx = core_next.adc;
            core_next.conv_pend = 1'b1;
        end

        // start or stop ends any transfer
        if (start_cond)
        begin
            core_next.bus = sadc_pkg::BUS_ADDR;
            core_next.bit_cnt = 4'h0;
            core_next.drive = 1'b0;
            core_next.ctrl_seen = 1'b0;
        end
        else if (stop_cond)
        begin
            core_next.bus = sadc_pkg::BUS_IDLE;
            core_next.drive = 1'b0;
        end
        else
        begin
            unique case (core_reg.bus)
                sadc_pkg::BUS_IDLE:
                begin
                    core_next.drive = 1'b0;
                end
                sadc_pkg::BUS_ADDR, sadc_pkg::BUS_WR_BYTE:
                begin
                    if (scl_rise)
                    begin
                        core_next.shift = {core_reg.shift[6:0],
                                           core_reg.sda_sync[1]};
                        core_next.bit_cnt = core_reg.bit_cnt + 4'h1;
                    end
                    else if (scl_fall
                             && core_reg.bit_cnt == sadc_pkg::BYTE_BITS)
                    begin
                        core_next.bit_cnt = 4'h0;
                        if (core_reg.bus == sadc_pkg::BUS_ADDR)
                        begin
                            if (core_reg.shift[7:1] == {ADDR_FIXED,
                                address_select_bit_two_i,
                                address_select_bit_one_i,
                                address_select_bit_zero_i})
                            begin
                                core_next.rw = core_reg.shift[0];
                                core_next.drive = 1'b1;
                                core_next.bus = sadc_pkg::BUS_ADDR_ACK;
                            end
                            else
                            begin
                                core_next.bus = sadc_pkg::BUS_IDLE;
                            end
                        end
                        else
                        begin
                            if (!core_reg.ctrl_seen)
                            begin
                                core_next.ctrl = core_reg.shift;
                                core_next.ctrl_seen = 1'b1;
                            end
                            else
                            begin
                                core_next.dac = core_reg.shift;
                            end
                            core_next.drive = 1'b1;
                            core_next.bus = sadc_pkg::BUS_WR_ACK;
                        end
                    end
                end
                sadc_pkg::BUS_ADDR_ACK, sadc_pkg::BUS_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        core_next.bit_cnt = 4'h0;
                        if (core_reg.bus == sadc_pkg::BUS_ADDR_ACK
                            && core_reg.rw)
                        begin
                            core_next.drive = ~core_next.tx[7];
                            core_next.bus = sadc_pkg::BUS_RD_BYTE;
                        end
                        else
                        begin
                            core_next.drive = 1'b0;
                            core_next.bus = sadc_pkg::BUS_WR_BYTE;
                        end
                    end
                end
                sadc_pkg::BUS_RD_BYTE:
                begin
                    if (scl_fall)
                    begin
                        if (core_reg.bit_cnt == sadc_pkg::LAST_TX_FALL)
                        begin
                            core_next.drive = 1'b0;
                            core_next.bus = sadc_pkg::BUS_RD_ACK;
                        end
                        else
                        begin
                            core_next.tx = {core_reg.tx[6:0], 1'b0};
                            core_next.drive = ~core_reg.tx[6];
                            core_next.bit_cnt = core_reg.bit_cnt + 4'h1;
                        end
                    end
                end
                sadc_pkg::BUS_RD_ACK:
                begin
                    if (scl_rise)
                    begin
                        core_next.acked = ~core_reg.sda_sync[1];
                    end
                    else if (scl_fall)
                    begin
                        core_next.bit_cnt = 4'h0;
                        if (core_reg.acked)
                        begin
                            core_next.drive = ~core_next.tx[7];
                            core_next.bus = sadc_pkg::BUS_RD_BYTE;
                        end
                        else
                        begin
                            core_next.bus = sadc_pkg::BUS_IDLE;
                        end
                    end
                end
                default:
                begin
                    core_next.bus = sadc_pkg::BUS_IDLE;
                    core_next.drive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            // control cleared, output and oscillator off
            core_reg <= '0;
            core_reg.scl_sync <= 2'h3;
            core_reg.sda_sync <= 2'h3;
            core_reg.scl_prev <= 1'b1;
            core_reg.sda_prev <= 1'b1;
            core_reg.ctrl <= sadc_pkg::CTRL_RESET;
            core_reg.dac <= sadc_pkg::DAC_RESET;
            core_reg.adc <= sadc_pkg::ADC_RESET;
        end
        else
        begin
            core_reg <= core_next;
        end
    end
endmodule

/* File: dv/sadc_core_monitor.sv */
`timescale 1ns/10ps
module sadc_core_monitor #(
    parameter int CONV_MIN_CYC = sadc_pkg::CONV_MIN_CYC
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic external_clock_select_i,
    input wire logic oscillator_pin_oe_o,
    input wire logic osc_enable_o,
    input wire logic [7:0] dac_code_o,
    input wire logic out_enable_o,
    input wire logic track_hold_o,
    input wire logic [1:0] input_mode_o,
    input wire logic [1:0] input_channel_o
);
    logic [15:0] gap_reg;
    logic [7:0] held_reg;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // saturating gap so the first conversion after reset is free
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            gap_reg <= 16'hffff;
        else if ($rose(track_hold_o))
            gap_reg <= 16'h0000;
        else if (gap_reg != 16'hffff)
            gap_reg <= gap_reg + 16'h0001;
        if (!track_hold_o)
            held_reg <= dac_code_o;
    end
    sequence conv_run_s;
        track_hold_o [*8] ##[1:1000] !track_hold_o;
    endsequence
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> sda_oe_o && !out_enable_o && !track_hold_o
        && dac_code_o == 8'h00 && input_channel_o == 2'h0)
        else $error("bad reset state");
    a_sda_scl_low: assert property (
        $changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
        else $error("sda moved with scl high");
    a_osc_pin_own: assert property (
        !external_clock_select_i [*4] |-> !oscillator_pin_oe_o)
        else $error("osc pin not driven");
    a_osc_with_out: assert property (
        out_enable_o |-> osc_enable_o)
        else $error("osc off with output on");
    a_conv_bounded: assert property (
        $rose(track_hold_o) |-> conv_run_s)
        else $error("bad conversion length");
    a_conv_spacing: assert property (
        $rose(track_hold_o) |-> int'(gap_reg) + 1 >= CONV_MIN_CYC)
        else $error("conversions too close");
    a_dac_restored: assert property (
        $fell(track_hold_o) |-> dac_code_o == held_reg)
        else $error("output level lost");
    a_chan_clamp: assert property (
        input_mode_o != 2'h0 |-> input_channel_o != 2'h3
        && (input_mode_o != 2'h3 || input_channel_o != 2'h2))
        else $error("channel not clamped");
endmodule
bind sadc_core sadc_core_monitor #(.CONV_MIN_CYC(CONV_MIN_CYC))
    sadc_core_monitor_inst (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_oe_o(sda_oe_o),
    .external_clock_select_i(external_clock_select_i),
    .oscillator_pin_oe_o(oscillator_pin_oe_o),
    .osc_enable_o(osc_enable_o),
    .dac_code_o(dac_code_o),
    .out_enable_o(out_enable_o),
    .track_hold_o(track_hold_o),
    .input_mode_o(input_mode_o),
    .input_channel_o(input_channel_o)
);

/* File: dv/sadc_bus_master.sv */
`timescale 1ns/10ps
module sadc_bus_master (
    input wire logic core_clk_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask
    task automatic send_bit(input logic b, output logic r);
        wait_cyc(2);
        sda_o = b;
        wait_cyc(2);
        scl_o = 1'b1;
        wait_cyc(4);
        r = sda_line_i;
        scl_o = 1'b0;
    endtask
    task automatic start_c();
        wait_cyc(2);
        sda_o = 1'b1;
        wait_cyc(2);
        scl_o = 1'b1;
        wait_cyc(4);
        sda_o = 1'b0;
        wait_cyc(4);
        scl_o = 1'b0;
    endtask
    task automatic stop_c();
        wait_cyc(2);
        sda_o = 1'b0;
        wait_cyc(2);
        scl_o = 1'b1;
        wait_cyc(4);
        sda_o = 1'b1;
        wait_cyc(4);
    endtask
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            send_bit(d[i], r);
        send_bit(1'b1, r);
        ack = !r;
    endtask
    task automatic read_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            send_bit(1'b1, d[i]);
        send_bit(!ack, r);
    endtask
endmodule

/* File: dv/tb_sadc_core.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) check_val(n, 8'(e), 8'(g))
module tb_sadc_core;
    localparam logic [3:0] FIXED = 4'h5;
    localparam logic [2:0] PINS = 3'h5;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic scl, m_sda, so, oe, oo, ooe, oen, aen, th, cmp;
    logic [7:0] dac;
    logic [1:0] mode, chan;
    wire sda_line;
    logic [7:0] ana [4] = '{8'h11, 8'h52, 8'ha3, 8'hf4};
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    // open drain with pull-up; released line reads high
    assign sda_line = m_sda & (oe | so);
    assign cmp = ana[chan] >= dac;
    initial
    begin
        forever #10 core_clk = ~core_clk;
    end
    sadc_core #(.CONV_MIN_CYC(50), .ADDR_FIXED(FIXED)) sadc_core_inst (
        .core_clk_i(core_clk), .rst_i(rst), .scl_i(scl),
        .sda_i(sda_line), .sda_o(so), .sda_oe_o(oe),
        .address_select_bit_zero_i(PINS[0]),
        .address_select_bit_one_i(PINS[1]),
        .address_select_bit_two_i(PINS[2]),
        .external_clock_select_i(1'b0), .oscillator_pin_i(1'b0),
        .oscillator_pin_o(oo), .oscillator_pin_oe_o(ooe),
        .osc_enable_o(oen), .comparator_i(cmp), .dac_code_o(dac),
        .out_enable_o(aen), .track_hold_o(th),
        .input_mode_o(mode), .input_channel_o(chan));
    sadc_bus_master sadc_bus_master_inst (.core_clk_i(core_clk),
        .sda_line_i(sda_line), .scl_o(scl), .sda_o(m_sda));
    task automatic check_val(input string n, input logic [7:0] e,
        input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            failures++;
            wrap_up();
        end
    end
    task automatic xfer(input logic [7:0] b, output logic a);
        sadc_bus_master_inst.write_byte(b, a);
    endtask
    task automatic read_one(input logic [7:0] e);
        logic a;
        logic [7:0] d;
        sadc_bus_master_inst.start_c();
        xfer({FIXED, PINS, 1'b1}, a);
        sadc_bus_master_inst.read_byte(1'b0, d);
        sadc_bus_master_inst.stop_c();
        `CHK("read byte", e, d);
        `CHK("read ack", 1'b1, a);
        sadc_bus_master_inst.wait_cyc(1000);
    endtask
    task automatic write_seq(input logic [7:0] c, input logic [7:0] v,
        input logic dac_too);
        logic [3:0] a;
        a = 4'hf;
        sadc_bus_master_inst.start_c();
        xfer({FIXED, PINS, 1'b0}, a[0]);
        xfer(c, a[1]);
        if (dac_too)
        begin
            xfer(~v, a[2]);
            xfer(v, a[3]);
        end
        sadc_bus_master_inst.stop_c();
        `CHK("write acks", 4'hf, a);
    endtask
    task automatic t_address();
        logic a;
        read_one(8'h80);
        sadc_bus_master_inst.start_c();
        xfer({FIXED, ~PINS, 1'b0}, a);
        sadc_bus_master_inst.stop_c();
        `CHK("foreign ack", 1'b0, a);
    endtask
    task automatic t_modes();
        logic [1:0] top [4] = '{2'h3, 2'h2, 2'h2, 2'h1};
        for (int m = 0; m < 4; m++)
        begin
            write_seq({2'b01, 2'(m), 4'h3}, 8'h00, 1'b0);
            `CHK("mode", m, mode);
            `CHK("clamped channel", top[m], chan);
        end
    endtask
    task automatic t_dac();
        write_seq(8'h47, 8'hc5, 1'b1);
        `CHK("dac tap", 8'hc5, dac);
        `CHK("output on", 1'b1, aen);
        `CHK("osc running", 1'b1, oen);
        `CHK("channel", 2'h3, chan);
        read_one(8'h11);
        `CHK("wrapped channel", 2'h0, chan);
        `CHK("dac held", 8'hc5, dac);
    endtask
    task automatic t_diff();
        write_seq(8'h77, 8'h00, 1'b0);
        read_one(8'hf4);
        `CHK("diff wrap", 2'h0, chan);
        read_one(8'hd2);
        `CHK("next channel", 2'h1, chan);
    endtask
    initial
    begin
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        repeat (3) @(negedge core_clk);
        t_address();
        t_modes();
        t_dac();
        t_diff();
        wrap_up();
    end
endmodule
